// ===== irq_pkg.sv
// Constants, register map and carrier types of the maskable interrupt block.
// Assumes one clock domain and word-addressed Avalon-MM register access.
package irq_pkg;

	// Source count and external-pin count.
	localparam int NUM_SRC = 25;
	localparam int NUM_EXT = 3;

	// Register index of each source's control register, in source order.
	localparam logic [6:0] CTRL_INDEX [NUM_SRC] = '{
		7'h41, 7'h42, 7'h47, 7'h4a, 7'h4d, 7'h4f, 7'h51, 7'h52, 7'h54,
		7'h56, 7'h58, 7'h59, 7'h5a, 7'h5c, 7'h5d, 7'h5e, 7'h5f, 7'h6c,
		7'h6d, 7'h6e, 7'h6f, 7'h70, 7'h71, 7'h72, 7'h73};

	// Interrupt number of each source, in source order.
	localparam logic [5:0] SRC_VECTOR [NUM_SRC] = '{
		6'h01, 6'h02, 6'h07, 6'h0a, 6'h0d, 6'h0f, 6'h11, 6'h12, 6'h14,
		6'h16, 6'h18, 6'h19, 6'h1a, 6'h1c, 6'h1d, 6'h1e, 6'h1f, 6'h2c,
		6'h2d, 6'h2e, 6'h2f, 6'h30, 6'h31, 6'h32, 6'h33};

	// Sources whose pending bit software cannot write (flash, timer C, serial).
	localparam logic [NUM_SRC-1:0] PEND_RO_MASK = 25'h0000025;
	localparam int SERIAL_SRC = 5;
	localparam int VMON_SRC = 23;
	// Source index of pin 0, pin 1 and pin 3, in slot order.
	localparam int EXT_SRC [NUM_EXT] = '{14, 11, 12};

	// Control register field positions.
	localparam int LVL_LSB = 0;
	localparam int LVL_MSB = 2;
	localparam int PEND_BIT = 3;
	localparam int EDGE_BIT = 4;

	// Reset values.
	localparam logic [2:0] LVL_RESET = 3'h0;
	localparam logic PEND_RESET = 1'b0;
	localparam logic EDGE_RESET = 1'b0;
	localparam logic WAITREQ_RESET = 1'b1;

	// Status word layout.
	localparam int FLG_D_BIT = 1;
	localparam int FLG_I_BIT = 6;
	localparam int FLG_U_BIT = 7;
	localparam int FLG_IPL_LSB = 12;
	localparam int FLG_IPL_MSB = 14;

	// Software trap numbers from this one up keep the stack-select flag.
	localparam logic [5:0] SW_KEEP_U_FIRST = 6'h20;

	// Entry sequence timing, in cycles counted from the acknowledge cycle.
	localparam logic [4:0] ENTRY_CYCLES = 5'h14;
	localparam logic [4:0] STEP_FLAGS = 5'h01;
	localparam logic [4:0] STEP_PUSH = 5'h02;
	localparam logic [4:0] NUM_PUSH = 5'h04;
	localparam logic [4:0] STEP_IPL = 5'h06;
	localparam logic [4:0] STEP_VECTOR = 5'h07;

	typedef enum logic [0:0] {SEQ_IDLE, SEQ_RUN} seq_t;

	// Software-visible control storage of all sources.
	typedef struct packed {
		logic [NUM_SRC-1:0][2:0] lvl;
		logic [NUM_SRC-1:0] pend;
		logic [NUM_EXT-1:0] edgeSel;
	} ctrl_t;

	typedef struct packed {
		logic found;
		logic [4:0] idx;
	} dec_t;

	typedef struct packed {
		logic found;
		logic [1:0] slot;
	} ext_t;

	// Acknowledge information read in the first entry step.
	typedef struct packed {
		logic valid;
		logic [5:0] number;
		logic [2:0] level;
	} ack_t;

	typedef struct packed {
		logic valid;
		logic [15:0] word;
	} flg_load_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} stack_wr_t;

	typedef struct packed {
		logic valid;
		logic [5:0] number;
	} vec_load_t;

	typedef struct packed {
		ctrl_t ctrl;
		logic [NUM_EXT-1:0] pinPrev;
		logic [NUM_EXT-1:0] adjPrev;
		logic waitReq;
		logic [31:0] rdData;
		seq_t seq;
		logic [4:0] cnt;
		logic isMask;
		logic keepU;
		logic [15:0] flgTemp;
		logic [19:0] pcSave;
		ack_t ack;
		flg_load_t cpu_status_word;
		stack_wr_t stk;
		vec_load_t vec;
		logic busy;
	} state_t;

endpackage

// ===== irq_level_select.sv
// Picks the highest-level eligible source, breaking ties by source index.
// Purely combinational; the caller registers whatever it takes from here.
`timescale 1ns/10ps
module irq_level_select
	import irq_pkg::*;
#(
	parameter bit LOW_INDEX_WINS = 1'b1
) (
	input wire logic [NUM_SRC-1:0][2:0] lvl,
	input wire logic [NUM_SRC-1:0] eligible,
	output logic found,
	output logic [4:0] idx,
	output logic [2:0] level
);

	// Static ranking: a later source replaces the best only on a strictly
	// higher level, so the lowest index wins a tie unless told otherwise.
	always_comb begin
		found = 1'b0;
		idx = 5'h00;
		level = 3'h0;
		for (int i = 0; i < NUM_SRC; i++) begin
			if (eligible[i] && (!found || lvl[i] > level ||
					(lvl[i] == level && !LOW_INDEX_WINS))) begin
				found = 1'b1;
				idx = 5'(i);
				level = lvl[i];
			end
		end
	end

endmodule

// ===== maskable_interrupt_priority_control.sv
// Maskable interrupt control: per-source control registers, acceptance
// test against the CPU status word, and the fixed 20-cycle entry sequence.
// Assumes the CPU core reports instruction boundaries, its status word and
// program counter, and applies the load and stack strobes this block emits.
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/10ps

// Behaviour
// - Three-bit level; zero disables, seven highest.
// - Threshold n admits levels above n only.
// - Accept needs enable flag, pending, level above threshold.
// - Flag, pending, level, threshold stored independently.
// - Cleared enable flag blocks all maskable sources.
// - Request sets pending; acceptance clears it.
// - Writing zero clears pending; writing one ignored.
// - Flash, timer C, serial pending bits read-only.
// - Level in bits 2..0, pending bit 3.
// - Pin registers: bit 4 edge select.
// - Changing edge select may set pending.
// - Voltage monitor register needs maskable select.
// - Serial register follows serial unit choice.
// - Judged at instruction end; entry next cycle.
// - String and multiply-accumulate instructions suspend immediately; only string instructions (stringInstr) do so here.
// - First step reports number, level; clears pending.
// - Save status; clear enable, single-step, stack-select.
// - Push status, push counter, set threshold, vector.
// - Entry sequence lasts twenty cycles.
// - Equal levels resolved by fixed hardware order.
// - Stacking is four byte-wide writes.
module maskable_interrupt_priority_control
	import irq_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [6:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [NUM_SRC-1:0] periphReq,
	input wire logic syncSerialReq,
	input wire logic twoWireReq,
	input wire logic serialUnitChoice,
	input wire logic vmonMaskableSelect,
	input wire logic [NUM_EXT-1:0] extPin,
	input wire logic [NUM_EXT-1:0] bothEdgeSelect,
	input wire logic instrDone,
	input wire logic stringInstr,
	input wire logic [15:0] cpuStatusWord,
	input wire logic [19:0] cpuPc,
	input wire logic swTrapReq,
	input wire logic [5:0] swTrapNum,
	output ack_t intAck,
	output flg_load_t flgLoad,
	output stack_wr_t stackWrite,
	output vec_load_t vecLoad,
	output logic seqBusy
);

	state_t st;
	state_t d;
	logic [NUM_EXT-1:0] adj;
	logic [NUM_EXT-1:0] extHit;
	logic [NUM_SRC-1:0] srcHit;
	logic [NUM_SRC-1:0] eligible;
	logic [NUM_SRC-1:0] clrSw;
	logic [NUM_SRC-1:0] clrAck;
	logic selFound;
	logic [4:0] selIdx;
	logic [2:0] selLevel;
	logic [2:0] processor_priority_threshold;
	logic busReq;
	logic wrAct;
	logic startSw;
	logic startMask;
	dec_t dec;
	ext_t ext;

	// Register index to source number; used by both read and write paths.
	function automatic dec_t decodeIndex(input logic [6:0] a);
		dec_t r;
		r = '0;
		for (int i = 0; i < NUM_SRC; i++) begin
			if (CTRL_INDEX[i] == a) begin
				r.found = 1'b1;
				r.idx = 5'(i);
			end
		end
		return r;
	endfunction

	// Source number to external-pin slot, if the source is a pin.
	function automatic ext_t extSlot(input logic [4:0] s);
		ext_t r;
		r = '0;
		for (int e = 0; e < NUM_EXT; e++) begin
			if (5'(EXT_SRC[e]) == s) begin
				r.found = 1'b1;
				r.slot = 2'(e);
			end
		end
		return r;
	endfunction

	// Pin edge detection. The selected edge is seen as a rise of the
	// polarity-adjusted level, so flipping the selector alone can look
	// like an edge; software must clear the pending bit after doing so.
	generate
		for (genvar g = 0; g < NUM_EXT; g++) begin : gPin
			assign adj[g] = ~(extPin[g] ^ st.ctrl.edgeSel[g]);
			assign extHit[g] = bothEdgeSelect[g] ?
				(extPin[g] ^ st.pinPrev[g]) :
				(adj[g] & ~st.adjPrev[g]);
		end
	endgenerate

	// Request routing and the acceptance test of each source.
	always_comb begin
		srcHit = periphReq;
		srcHit[SERIAL_SRC] = serialUnitChoice ? twoWireReq : syncSerialReq;
		for (int e = 0; e < NUM_EXT; e++) begin
			srcHit[EXT_SRC[e]] = extHit[e];
		end
		for (int i = 0; i < NUM_SRC; i++) begin
			// Level zero never exceeds a threshold, so it stays disabled.
			eligible[i] = cpuStatusWord[FLG_I_BIT] && st.ctrl.pend[i] &&
				(st.ctrl.lvl[i] > processor_priority_threshold);
		end
		eligible[VMON_SRC] = eligible[VMON_SRC] && vmonMaskableSelect;
	end

	assign processor_priority_threshold = cpuStatusWord[FLG_IPL_MSB:FLG_IPL_LSB];

	irq_level_select #(
		.LOW_INDEX_WINS(1'b1)
	) uSelect (
		.lvl(st.ctrl.lvl),
		.eligible(eligible),
		.found(selFound),
		.idx(selIdx),
		.level(selLevel)
	);

	// Bus handshake: a request is answered one cycle later with
	// waitrequest low; the write lands on that same edge.
	assign busReq = avs_read | avs_write;
	assign wrAct = avs_write && !st.waitReq && avs_byteenable[0];
	assign dec = decodeIndex(avs_address);
	assign ext = extSlot(dec.idx);

	// Outside string instructions a request waits for the boundary.
	assign startSw = (st.seq == SEQ_IDLE) && swTrapReq;
	assign startMask = (st.seq == SEQ_IDLE) && !swTrapReq &&
		(instrDone || stringInstr) && selFound;

	// Next-state logic for registers, pending bits and entry sequence.
	always_comb begin
		d = st;
		d.ack.valid = 1'b0;
		d.cpu_status_word.valid = 1'b0;
		d.stk.valid = 1'b0;
		d.vec.valid = 1'b0;
		d.pinPrev = extPin;
		d.adjPrev = adj;
		d.waitReq = !(busReq && st.waitReq);
		clrSw = '0;
		clrAck = '0;
		if (busReq && st.waitReq) begin
			d.rdData = 32'h0000_0000;
			if (dec.found) begin
				d.rdData[LVL_MSB:LVL_LSB] = st.ctrl.lvl[dec.idx];
				d.rdData[PEND_BIT] = st.ctrl.pend[dec.idx];
				if (ext.found) begin
					d.rdData[EDGE_BIT] = st.ctrl.edgeSel[ext.slot];
				end
			end
		end
		// Each field is written alone; no write reaches the CPU flags.
		if (wrAct && dec.found) begin
			d.ctrl.lvl[dec.idx] = avs_writedata[LVL_MSB:LVL_LSB];
			if (!PEND_RO_MASK[dec.idx] && !avs_writedata[PEND_BIT]) begin
				clrSw[dec.idx] = 1'b1;
			end
			if (ext.found) begin
				d.ctrl.edgeSel[ext.slot] = avs_writedata[EDGE_BIT];
			end
		end
		if (startMask) begin
			clrAck[selIdx] = 1'b1;
		end
		// A new request wins over a clear in the same cycle.
		d.ctrl.pend = (st.ctrl.pend & ~clrSw & ~clrAck) | srcHit;
		case (st.seq)
			SEQ_IDLE: begin
				if (startSw || startMask) begin
					d.seq = SEQ_RUN;
					d.cnt = 5'h00;
					d.busy = 1'b1;
					d.ack.valid = 1'b1;
					d.ack.number = startSw ? swTrapNum : SRC_VECTOR[selIdx];
					d.ack.level = startSw ? 3'h0 : selLevel;
					d.isMask = startMask;
					d.keepU = startSw && (swTrapNum >= SW_KEEP_U_FIRST);
					d.flgTemp = cpuStatusWord;
					d.pcSave = cpuPc;
				end
			end
			SEQ_RUN: begin
				d.cnt = 5'(st.cnt + 5'h01);
				if (st.cnt == 5'(ENTRY_CYCLES - 5'h01)) begin
					d.seq = SEQ_IDLE;
					d.busy = 1'b0;
					d.cnt = 5'h00;
				end else if (d.cnt == STEP_FLAGS) begin
					d.cpu_status_word.valid = 1'b1;
					d.cpu_status_word.word = st.flgTemp;
					d.cpu_status_word.word[FLG_I_BIT] = 1'b0;
					d.cpu_status_word.word[FLG_D_BIT] = 1'b0;
					if (!st.keepU) begin
						d.cpu_status_word.word[FLG_U_BIT] = 1'b0;
					end
				end else if (d.cnt >= STEP_PUSH &&
						d.cnt < 5'(STEP_PUSH + NUM_PUSH)) begin
					// Counter top nibble with status top nibble first, then low status byte, then the counter.
					d.stk.valid = 1'b1;
					case (2'(d.cnt - STEP_PUSH))
						2'h0: d.stk.data = {st.pcSave[19:16], st.flgTemp[15:12]};
						2'h1: d.stk.data = st.flgTemp[7:0];
						2'h2: d.stk.data = st.pcSave[15:8];
						default: d.stk.data = st.pcSave[7:0];
					endcase
				end else if (d.cnt == STEP_IPL) begin
					// Software traps leave the threshold alone.
					d.cpu_status_word.valid = 1'b1;
					if (st.isMask) begin
						d.cpu_status_word.word[FLG_IPL_MSB:FLG_IPL_LSB] = st.ack.level;
					end
				end else if (d.cnt == STEP_VECTOR) begin
					d.vec.valid = 1'b1;
					d.vec.number = st.ack.number;
				end
			end
			default: begin
				d.seq = SEQ_IDLE;
			end
		endcase
	end

	// State register; pending bits start cleared rather than unknown.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= '0;
			// Track the pins through reset so no false edge follows it.
			st.pinPrev <= extPin;
			st.adjPrev <= ~extPin;
			st.waitReq <= WAITREQ_RESET;
			st.seq <= SEQ_IDLE;
			st.ctrl.lvl <= {NUM_SRC{LVL_RESET}};
			st.ctrl.pend <= {NUM_SRC{PEND_RESET}};
			st.ctrl.edgeSel <= {NUM_EXT{EDGE_RESET}};
		end else begin
			st <= d;
		end
	end

	// Outputs come straight from the state register.
	assign avs_readdata = st.rdData;
	assign avs_waitrequest = st.waitReq;
	assign intAck = st.ack;
	assign flgLoad = st.cpu_status_word;
	assign stackWrite = st.stk;
	assign vecLoad = st.vec;
	assign seqBusy = st.busy;

	// Helper state watched only by the checks below.
	logic [5:0] busyLen;
	logic clrSeen;
	logic roSeen;
	logic [4:0] wrIdxQ;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			busyLen <= 6'h00;
			clrSeen <= 1'b0;
			roSeen <= 1'b0;
			wrIdxQ <= 5'h00;
		end else begin
			busyLen <= seqBusy ? 6'(busyLen + 6'h01) : 6'h00;
			clrSeen <= wrAct && dec.found && !avs_writedata[PEND_BIT] &&
				!PEND_RO_MASK[dec.idx] && !srcHit[dec.idx];
			roSeen <= wrAct && dec.found && PEND_RO_MASK[dec.idx] &&
				st.ctrl.pend[dec.idx] && !(startMask && selIdx == dec.idx);
			wrIdxQ <= dec.idx;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence sAck;
		intAck.valid && !flgLoad.valid;
	endsequence
	sequence sPush;
		stackWrite.valid [*4];
	endsequence
	sequence sTail;
		flgLoad.valid ##1 vecLoad.valid;
	endsequence

	AST_LEVEL_NONZERO: assert property (startMask |-> selLevel != 3'h0)
		else $error("Accepted a source with level zero.");
	AST_ABOVE_THRESHOLD: assert property (startMask |-> selLevel > processor_priority_threshold)
		else $error("Accepted level not above threshold.");
	AST_ACCEPT_TERMS: assert property (startMask |->
			st.ctrl.pend[selIdx] && cpuStatusWord[FLG_I_BIT])
		else $error("Accepted without pending bit and enable flag.");
	AST_ENABLE_BLOCKS: assert property (!cpuStatusWord[FLG_I_BIT] |->
			!startMask)
		else $error("Maskable entry with enable flag clear.");
	AST_HIT_SETS: assert property (|srcHit |=>
			((st.ctrl.pend & $past(srcHit)) == $past(srcHit)))
		else $error("Request did not set its pending bit.");
	AST_WRITE_ONE_KEEPS: assert property ((wrAct && avs_writedata[PEND_BIT]
			&& !startMask) |=> st.ctrl.pend == ($past(st.ctrl.pend) |
			$past(srcHit)))
		else $error("Write of one disturbed a pending bit.");
	AST_SW_CLEAR: assert property (clrSeen |-> !st.ctrl.pend[wrIdxQ])
		else $error("Write of zero did not clear pending.");
	AST_RO_PENDING: assert property (roSeen |-> st.ctrl.pend[wrIdxQ])
		else $error("Read-only pending bit was cleared by a write.");
	AST_VMON_GATE: assert property ((startMask && selIdx == 5'(VMON_SRC))
			|-> vmonMaskableSelect)
		else $error("Voltage monitor taken while not maskable.");
	AST_BOUNDARY: assert property (startMask |-> instrDone || stringInstr)
		else $error("Entry started inside an instruction.");
	AST_ACK_CLEARS: assert property (startMask && !srcHit[selIdx] |=>
			intAck.valid && !st.ctrl.pend[$past(selIdx)])
		else $error("Acknowledge step missing or pending not cleared.");
	AST_FLAGS_CLEAR: assert property ($rose(flgLoad.valid) && st.cnt ==
			STEP_FLAGS |-> !flgLoad.word[FLG_I_BIT] &&
			!flgLoad.word[FLG_D_BIT])
		else $error("Entry flags not cleared.");
	AST_ENTRY_ORDER: assert property ((startSw || startMask) |=>
			sAck ##1 flgLoad.valid ##1 sPush ##1 sTail)
		else $error("Entry steps out of order.");
	AST_ENTRY_LEN: assert property ($fell(seqBusy) |->
			busyLen == 6'(ENTRY_CYCLES))
		else $error("Entry sequence not twenty cycles long.");
	AST_PICK_ELIGIBLE: assert property (selFound |->
			eligible[selIdx] && selLevel == st.ctrl.lvl[selIdx])
		else $error("Picked source is not eligible.");

endmodule

// ===== cpu_model.sv
// Behavioural CPU core beside the interrupt block: status word, counter
// and instruction boundaries. Assumes one-cycle load strobes from the block.
`timescale 1ns/10ps
module cpu_model
	import irq_pkg::*;
#(
	parameter logic [19:0] PC_RESET = 20'h0a5c3
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic flgSet,
	input wire logic [15:0] flgVal,
	input wire flg_load_t flgLoad,
	input wire vec_load_t vecLoad,
	output logic [15:0] cpuStatusWord,
	output logic [19:0] cpuPc,
	output logic instrDone
);
	logic [1:0] phaseQ;

	// The counter holds still between entries so stacked bytes are known.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			phaseQ <= 2'h0;
			cpuStatusWord <= 16'h0000;
			cpuPc <= PC_RESET;
		end else begin
			phaseQ <= phaseQ + 2'h1;
			if (flgSet) begin
				cpuStatusWord <= flgVal;
			end else if (flgLoad.valid) begin
				cpuStatusWord <= flgLoad.word;
			end
			if (vecLoad.valid) begin
				cpuPc <= {12'h000, vecLoad.number, 2'h0};
			end
		end
	end

	// Every fourth cycle ends an instruction, so requests wait a while.
	assign instrDone = (phaseQ == 2'h3);
endmodule

// ===== maskable_interrupt_priority_control_bench.sv
// Self-checking bench of the maskable interrupt block with a CPU model.
// Assumes the register map and entry order given in the package.
`timescale 1ns/10ps
module maskable_interrupt_priority_control_bench;
	import irq_pkg::*;
	localparam logic [19:0] PC0 = 20'h0a5c3;
	logic clk, sys_rst, avs_read, avs_write, avs_waitrequest;
	logic [6:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable;
	logic [NUM_SRC-1:0] periphReq;
	logic syncSerialReq, serialUnitChoice, vmonMaskableSelect;
	logic [NUM_EXT-1:0] extPin;
	logic instrDone, seqBusy, flgSet, swTrapReq;
	logic [5:0] swTrapNum;
	logic [15:0] cpuStatusWord, flgVal;
	logic [19:0] cpuPc, pcExp;
	ack_t intAck;
	flg_load_t flgLoad;
	stack_wr_t stackWrite;
	vec_load_t vecLoad;
	logic [31:0] expQ[$];
	logic [7:0] d;
	int fails, nTests, cycles, busyCnt;

	maskable_interrupt_priority_control dut_u (.clk(clk),
		.sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .periphReq(periphReq),
		.syncSerialReq(syncSerialReq), .twoWireReq(1'b0),
		.serialUnitChoice(serialUnitChoice),
		.vmonMaskableSelect(vmonMaskableSelect), .extPin(extPin),
		.bothEdgeSelect(3'h0), .instrDone(instrDone), .stringInstr(1'b0),
		.cpuStatusWord(cpuStatusWord), .cpuPc(cpuPc), .swTrapReq(swTrapReq),
		.swTrapNum(swTrapNum), .intAck(intAck), .flgLoad(flgLoad),
		.stackWrite(stackWrite), .vecLoad(vecLoad), .seqBusy(seqBusy));

	cpu_model #(.PC_RESET(PC0)) cpu_u (.clk(clk), .sys_rst(sys_rst),
		.flgSet(flgSet), .flgVal(flgVal), .flgLoad(flgLoad),
		.vecLoad(vecLoad), .cpuStatusWord(cpuStatusWord), .cpuPc(cpuPc),
		.instrDone(instrDone));

	// Free-running 20 MHz clock.
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", nTests, fails);
		if (fails == 0 && nTests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// An unexpected result meets an unknown note, so it always mismatches.
	task automatic got(input logic [31:0] seen);
		if (expQ.size() == 0) begin
			chk(seen, 32'hxxxxxxxx);
		end else begin
			chk(seen, expQ.pop_front());
		end
	endtask

	// One Avalon access; the request holds until waitrequest is seen low.
	task automatic bus(input logic wr, input logic [6:0] a,
		input logic [7:0] dat, input logic [3:0] be);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= {24'h0, dat};
		avs_byteenable <= be;
		avs_read <= ~wr;
		avs_write <= wr;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		if (n >= 40) fails++;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] dat);
		bus(1'b1, a, dat, 4'h1);
	endtask

	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		expQ.push_back({24'h0, e});
		bus(1'b0, a, 8'h00, 4'h1);
	endtask

	task automatic pulse(input logic [NUM_SRC-1:0] m);
		@(posedge clk);
		periphReq <= m;
		@(posedge clk);
		periphReq <= '0;
	endtask

	task automatic setS(input logic [15:0] v);
		@(posedge clk);
		flgSet <= 1'b1;
		flgVal <= v;
		@(posedge clk);
		flgSet <= 1'b0;
	endtask

	// Notes every result of one entry, worked out from status s.
	task automatic entry(input logic [5:0] n, input logic [2:0] l,
		input logic [15:0] s);
		logic [15:0] f;
		// Level zero marks a software trap; traps from 32 keep stack-select.
		f = s & ((l == 3'h0 && n >= 6'h20) ? 16'hffbd : 16'hff3d);
		expQ.push_back({23'h0, n, l});
		expQ.push_back({16'h0, f});
		expQ.push_back({24'h0, pcExp[19:16], s[15:12]});
		expQ.push_back({24'h0, s[7:0]});
		expQ.push_back({24'h0, pcExp[15:8]});
		expQ.push_back({24'h0, pcExp[7:0]});
		if (l != 3'h0) f[14:12] = l;
		expQ.push_back({16'h0, f});
		expQ.push_back({26'h0, n});
		pcExp = {12'h000, n, 2'h0};
	endtask

	// Watcher: every result is matched against the oldest note.
	always @(posedge clk) begin
		cycles++;
		if (cycles > 6000) begin
			fails++;
			report_and_stop();
		end else if (sys_rst === 1'b0) begin
			if (avs_read && avs_waitrequest === 1'b0) got(avs_readdata);
			if (intAck.valid === 1'b1) got({23'h0, intAck.number, intAck.level});
			if (flgLoad.valid === 1'b1) got({16'h0, flgLoad.word});
			if (stackWrite.valid === 1'b1) got({24'h0, stackWrite.data});
			if (vecLoad.valid === 1'b1) got({26'h0, vecLoad.number});
			if (seqBusy === 1'b1) begin
				busyCnt++;
			end else if (busyCnt != 0) begin
				chk(busyCnt, 32'(ENTRY_CYCLES));
				busyCnt = 0;
			end
		end
	end

	// Main sequence.
	initial begin
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		{periphReq, syncSerialReq, serialUnitChoice, flgSet} = '0;
		{swTrapReq, swTrapNum} = '0;
		avs_byteenable = 4'h1;
		vmonMaskableSelect = 1'b0;
		extPin = 3'h7;
		flgVal = 16'h0000;
		{fails, nTests, cycles, busyCnt} = '0;
		pcExp = PC0;
		void'($urandom(32'he486be62));
		sys_rst = 1'b1;
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < NUM_SRC; i++) rd(CTRL_INDEX[i], 8'h00);
		rd(7'h40, 8'h00);
		$display("reset values done");
		for (int i = 0; i < NUM_SRC; i++) begin
			d = 8'($urandom);
			if (i == 11 || i == 12 || i == 14) d[4] = 1'b0;
			wr(CTRL_INDEX[i], d);
			rd(CTRL_INDEX[i], {5'h00, d[2:0]});
		end
		wr(7'h42, 8'h03);
		bus(1'b1, 7'h42, 8'h06, 4'h0);
		rd(7'h42, 8'h03);
		for (int i = 0; i < NUM_SRC; i++) wr(CTRL_INDEX[i], 8'h00);
		$display("field storage done");
		// Rewriting the edge select may set pending, so clear it again.
		wr(7'h5d, 8'h10);
		wr(7'h5d, 8'h10);
		rd(7'h5d, 8'h10);
		extPin[0] <= 1'b0;
		repeat (4) @(posedge clk);
		rd(7'h5d, 8'h10);
		extPin[0] <= 1'b1;
		repeat (4) @(posedge clk);
		rd(7'h5d, 8'h18);
		wr(7'h5d, 8'h10);
		$display("pin edge done");
		pulse(25'h0000002);
		rd(7'h42, 8'h08);
		wr(7'h42, 8'h00);
		rd(7'h42, 8'h00);
		wr(7'h42, 8'h08);
		rd(7'h42, 8'h00);
		pulse(25'h0000002);
		wr(7'h42, 8'h0d);
		rd(7'h42, 8'h0d);
		pulse(25'h0000001);
		wr(7'h41, 8'h00);
		rd(7'h41, 8'h08);
		@(posedge clk);
		syncSerialReq <= 1'b1;
		@(posedge clk);
		syncSerialReq <= 1'b0;
		wr(7'h4f, 8'h00);
		rd(7'h4f, 8'h08);
		$display("pending bits done");
		repeat (20) @(posedge clk);
		setS(16'h5040);
		repeat (20) @(posedge clk);
		wr(7'h4a, 8'h06);
		wr(7'h4d, 8'h06);
		entry(6'h0a, 3'h6, 16'h5040);
		pulse(25'h0000018);
		repeat (30) @(posedge clk);
		rd(7'h4a, 8'h06);
		entry(6'h0d, 3'h6, 16'h4040);
		setS(16'h4040);
		repeat (30) @(posedge clk);
		entry(6'h02, 3'h5, 16'h4040);
		setS(16'h4040);
		repeat (30) @(posedge clk);
		rd(7'h42, 8'h05);
		$display("acceptance done");
		wr(7'h72, 8'h07);
		pulse(25'h0800000);
		setS(16'h0040);
		repeat (20) @(posedge clk);
		entry(6'h32, 3'h7, 16'h0040);
		vmonMaskableSelect <= 1'b1;
		repeat (40) @(posedge clk);
		$display("voltage monitor done");
		setS(16'h0080);
		entry(6'h21, 3'h0, 16'h0080);
		@(posedge clk);
		swTrapReq <= 1'b1;
		swTrapNum <= 6'h21;
		@(posedge clk);
		swTrapReq <= 1'b0;
		repeat (30) @(posedge clk);
		$display("software trap done");
		if (expQ.size() != 0) fails++;
		report_and_stop();
	end
endmodule
